// ---- hw/gpg_group_irq.sv ----
/*
  Two grouped pin-interrupt units with pin synchronisers, status and wake-up.
  Assumes pins are asynchronous to ref_clk and that a power controller
  returns the part to run mode (power_mode = run) after wake_req.
*/
`timescale 1ns/100ps
module gpg_group_irq (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [gpg_pkg::GPG_NUM_PINS-1:0] pin_in,
  input wire logic [gpg_pkg::GPG_NUM_PINS-1:0] pin_enable_a,
  input wire logic [gpg_pkg::GPG_NUM_PINS-1:0] pin_polarity_a,
  input wire logic combine_and_a,
  input wire logic trig_edge_a,
  input wire logic clear_status_a,
  input wire logic [gpg_pkg::GPG_NUM_PINS-1:0] pin_enable_b,
  input wire logic [gpg_pkg::GPG_NUM_PINS-1:0] pin_polarity_b,
  input wire logic combine_and_b,
  input wire logic trig_edge_b,
  input wire logic clear_status_b,
  input wire logic [1:0] power_mode,
  output logic status_a,
  output logic status_b,
  output logic pin_group_irq_a,
  output logic pin_group_irq_b,
  output logic wake_req
);
  import gpg_pkg::*;

  logic [GPG_NUM_PINS-1:0] sync1_q;
  logic [GPG_NUM_PINS-1:0] pins_q;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      pins_q <= '0;
    end
    else
    begin
      sync1_q <= pin_in;
      pins_q <= sync1_q;
    end
  end

  wire [GPG_NUM_PINS-1:0] en_g [GPG_NUM_GROUPS];
  wire [GPG_NUM_PINS-1:0] pol_g [GPG_NUM_GROUPS];
  wire and_g [GPG_NUM_GROUPS];
  wire edge_g [GPG_NUM_GROUPS];
  wire clr_g [GPG_NUM_GROUPS];
  wire stat_g [GPG_NUM_GROUPS];
  wire cond_g [GPG_NUM_GROUPS];
  wire irq_g [GPG_NUM_GROUPS];
  assign en_g[0] = pin_enable_a;
  assign en_g[1] = pin_enable_b;
  assign pol_g[0] = pin_polarity_a;
  assign pol_g[1] = pin_polarity_b;
  assign and_g[0] = combine_and_a;
  assign and_g[1] = combine_and_b;
  assign edge_g[0] = trig_edge_a;
  assign edge_g[1] = trig_edge_b;
  assign clr_g[0] = clear_status_a;
  assign clr_g[1] = clear_status_b;

  wire sleeping = (power_mode != GPG_PM_RUN);

  genvar g;
  generate
    for (g = 0; g < GPG_NUM_GROUPS; g++)
    begin : grp
      // Polarity high: pin active when high; low: active when low
      wire [GPG_NUM_PINS-1:0] active = ~(pins_q ^ pol_g[g]);
      // Disabled pins read as neutral for the chosen combine
      wire [GPG_NUM_PINS-1:0] or_terms = active & en_g[g];
      wire [GPG_NUM_PINS-1:0] and_terms = active | ~en_g[g];
      wire any_en = |en_g[g];
      wire cond = and_g[g] ? (any_en & (&and_terms)) : (|or_terms);
      logic cond_q;
      logic stat_q;
      wire rise = cond & ~cond_q;
      // Edge: sticky, set wins over clear; level: follows condition
      wire stat_d = edge_g[g] ? (rise | (stat_q & ~clr_g[g])) : cond;
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          cond_q <= 1'b0;
          stat_q <= 1'b0;
        end
        else
        begin
          cond_q <= cond;
          stat_q <= stat_d;
        end
      end
      assign stat_g[g] = stat_q;
      assign cond_g[g] = cond;
      // Request withheld while the part is still in a low-power state
      assign irq_g[g] = stat_q & ~sleeping;
    end
  endgenerate

  logic wake_q;
  // Any pending status wakes the part from any low-power mode
  wire wake_d = sleeping & (stat_g[0] | stat_g[1]);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wake_q <= 1'b0;
    else
      wake_q <= wake_d;
  end

  assign status_a = stat_g[0];
  assign status_b = stat_g[1];
  assign pin_group_irq_a = irq_g[0];
  assign pin_group_irq_b = irq_g[1];
  assign wake_req = wake_q;

  property p_edge_sticky;
    @(posedge ref_clk) disable iff (rst)
      (trig_edge_a && $past(trig_edge_a) && status_a && !clear_status_a) |=> status_a;
  endproperty
  a_edge_sticky: assert property (p_edge_sticky) else $error("edge status lost");

  property p_edge_set;
    @(posedge ref_clk) disable iff (rst)
      (trig_edge_a && cond_g[0] && !$past(cond_g[0])) |=> status_a;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge not latched");

  property p_level_follow;
    @(posedge ref_clk) disable iff (rst)
      (!trig_edge_b) |=> (status_b == $past(cond_g[1]));
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level mismatch");

  property p_clear;
    @(posedge ref_clk) disable iff (rst)
      (!$past(rst) && trig_edge_a && clear_status_a && !(cond_g[0] && !$past(cond_g[0])))
        |=> !status_a;
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");

  property p_disabled_none;
    @(posedge ref_clk) disable iff (rst)
      (pin_enable_a == '0 && !combine_and_a) |-> !cond_g[0];
  endproperty
  a_disabled_none: assert property (p_disabled_none) else $error("disabled pins act");

  property p_irq_gate;
    @(posedge ref_clk) disable iff (rst)
      pin_group_irq_b |-> (status_b && power_mode == GPG_PM_RUN);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while asleep");

  property p_irq_run;
    @(posedge ref_clk) disable iff (rst)
      (status_a && power_mode == GPG_PM_RUN) |-> pin_group_irq_a;
  endproperty
  a_irq_run: assert property (p_irq_run) else $error("irq missing");

  property p_wake;
    @(posedge ref_clk) disable iff (rst)
      (power_mode != GPG_PM_RUN && (status_a || status_b)) |=> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_and_one;
    @(posedge ref_clk) disable iff (rst)
      (combine_and_b && pin_enable_b == 32'h0000_0001 && pin_polarity_b[0]) |->
        (cond_g[1] == pins_q[0]);
  endproperty
  a_and_one: assert property (p_and_one) else $error("and combine wrong");

  property p_or_one;
    @(posedge ref_clk) disable iff (rst)
      (!combine_and_b && pin_enable_b == 32'h0000_0001 && !pin_polarity_b[0]) |->
        (cond_g[1] == !pins_q[0]);
  endproperty
  a_or_one: assert property (p_or_one) else $error("or combine wrong");

  property p_edge_set_b;
    @(posedge ref_clk) disable iff (rst)
      (trig_edge_b && cond_g[1] && !$past(cond_g[1])) |=> status_b;
  endproperty
  a_edge_set_b: assert property (p_edge_set_b) else $error("edge b not latched");

  property p_edge_sticky_b;
    @(posedge ref_clk) disable iff (rst)
      (trig_edge_b && $past(trig_edge_b) && status_b && !clear_status_b) |=> status_b;
  endproperty
  a_edge_sticky_b: assert property (p_edge_sticky_b) else $error("edge b status lost");

  property p_clear_b;
    @(posedge ref_clk) disable iff (rst)
      (!$past(rst) && trig_edge_b && clear_status_b && !(cond_g[1] && !$past(cond_g[1])))
        |=> !status_b;
  endproperty
  a_clear_b: assert property (p_clear_b) else $error("clear b ignored");

  property p_level_follow_a;
    @(posedge ref_clk) disable iff (rst)
      (!trig_edge_a) |=> (status_a == $past(cond_g[0]));
  endproperty
  a_level_follow_a: assert property (p_level_follow_a) else $error("level a mismatch");

  property p_irq_gate_a;
    @(posedge ref_clk) disable iff (rst)
      pin_group_irq_a |-> (status_a && power_mode == GPG_PM_RUN);
  endproperty
  a_irq_gate_a: assert property (p_irq_gate_a) else $error("irq a while asleep");

  property p_irq_run_b;
    @(posedge ref_clk) disable iff (rst)
      (status_b && power_mode == GPG_PM_RUN) |-> pin_group_irq_b;
  endproperty
  a_irq_run_b: assert property (p_irq_run_b) else $error("irq b missing");

  property p_wake_quiet;
    @(posedge ref_clk) disable iff (rst)
      (power_mode == GPG_PM_RUN) |=> !wake_req;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("wake while running");

  c_edge: cover property (@(posedge ref_clk) disable iff (rst) trig_edge_a && $rose(status_a));
  c_clear: cover property (@(posedge ref_clk) disable iff (rst) $fell(status_a));
  c_wake: cover property (@(posedge ref_clk) disable iff (rst) $rose(wake_req));
  c_both: cover property (@(posedge ref_clk) disable iff (rst) pin_group_irq_a && pin_group_irq_b);
  c_edge_b: cover property (@(posedge ref_clk) disable iff (rst) trig_edge_b && $rose(status_b));
endmodule

// ---- hw/gpg_pkg.sv ----
/*
  Shared constants for the grouped pin-interrupt block.
  Assumes a single system clock and a synchronous active-high reset.
*/
// Functional notes
// - Two separate grouped-interrupt units, each with its own pattern and request.
// - Per-pin enable; disabled pins never affect the group condition.
// - Each enabled pin has a polarity: active when high or when low.
// - Group setting combines enabled active pins by OR or by AND.
// - Group setting picks level-sensitive or edge-triggered request.
// - Pattern present raises the unit's request toward the processor.
// - In power-saving state, wake-up is raised first, request afterwards.
// - Writing one to the status bit clears a pending request; the clear inputs act in edge mode only.
// - A match wakes the part from sleep, deep-sleep and power-down.
package gpg_pkg;
  localparam int GPG_NUM_PINS = 32;
  localparam int GPG_NUM_GROUPS = 2;
  localparam logic GPG_COMB_OR = 1'b0;
  localparam logic GPG_COMB_AND = 1'b1;
  localparam logic GPG_TRIG_LEVEL = 1'b0;
  localparam logic GPG_TRIG_EDGE = 1'b1;
  localparam logic [GPG_NUM_PINS-1:0] GPG_ENABLE_RST = 32'h0000_0000;
  localparam logic [GPG_NUM_PINS-1:0] GPG_POL_RST = 32'h0000_0000;
  localparam logic [1:0] GPG_PM_RUN = 2'h0;
  localparam logic [1:0] GPG_PM_SLEEP = 2'h1;
  localparam logic [1:0] GPG_PM_DEEP_SLEEP = 2'h2;
  localparam logic [1:0] GPG_PM_POWER_DOWN = 2'h3;
endpackage

// ---- testbench/gpg_pwr_model.sv ----
/*
  Power controller model beside the grouped pin-interrupt block.
  Assumes the bench commands the low-power mode and reacts to wake_req.
*/
`timescale 1ns/100ps
module gpg_pwr_model #(
  parameter int WAKE_DLY = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] sleep_cmd,
  input wire logic wake_req,
  output logic [1:0] power_mode
);
  logic [1:0] mode_q;
  int cnt_q;
  assign power_mode = mode_q;
  // Wake-up returns the part to run some cycles later
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_q <= 2'h0;
      cnt_q <= 0;
    end
    else if (wake_req || cnt_q != 0)
    begin
      cnt_q <= (cnt_q == WAKE_DLY - 1) ? 0 : cnt_q + 1;
      if (cnt_q == WAKE_DLY - 1)
        mode_q <= 2'h0;
    end
    else
      mode_q <= sleep_cmd;
  end
endmodule

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench for the grouped pin-interrupt block.
  Assumes inputs change on the falling edge of ref_clk.
*/
`timescale 1ns/100ps
module tb_top;
  import gpg_pkg::*;
  typedef struct {logic [31:0] en, pol, pin; logic cand, exp;} gpg_row_s;
  logic clk = 0, rst = 1, ca = 0, cb = 0, ta = 0, tb = 0, xa = 0, xb = 0;
  logic wk, sa, sb, ia, ib;
  logic [31:0] pin = 0, ea = 0, pa = 0, eb = 0, pb = 0;
  logic [1:0] cmd = 0, pm;
  int n_fail = 0, samples_checked = 0, k;
  gpg_row_s rows[7] = '{'{32'h1, 32'h1, 32'h1, 1'b0, 1'b1}, '{32'h1, 32'h1, 32'h0, 1'b0, 1'b0},
    '{32'h1, 32'h0, 32'h0, 1'b0, 1'b1}, '{32'h3, 32'h3, 32'h1, 1'b1, 1'b0},
    '{32'h3, 32'h3, 32'h3, 1'b1, 1'b1}, '{32'h0, 32'h0, 32'h0, 1'b1, 1'b0},
    '{32'h2, 32'h2, 32'h1, 1'b0, 1'b0}};
  gpg_group_irq gpg_group_irq_inst (.ref_clk(clk), .rst(rst), .pin_in(pin), .pin_enable_a(ea),
    .pin_polarity_a(pa), .combine_and_a(ca), .trig_edge_a(ta), .clear_status_a(xa),
    .pin_enable_b(eb), .pin_polarity_b(pb), .combine_and_b(cb), .trig_edge_b(tb),
    .clear_status_b(xb), .power_mode(pm), .status_a(sa), .status_b(sb),
    .pin_group_irq_a(ia), .pin_group_irq_b(ib), .wake_req(wk));
  gpg_pwr_model gpg_pwr_model_inst (.ref_clk(clk), .rst(rst), .sleep_cmd(cmd), .wake_req(wk),
    .power_mode(pm));
  initial forever #2.5 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input string nm, input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %b seen %b", nm, exp, seen);
      n_fail++;
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    tick(10);
    check("irq_a", ia, 1'b0);
    rst = 0;
    foreach (rows[i])
    begin
      {ea, eb, pa, pb, ca, cb, pin} = {rows[i].en, rows[i].en, rows[i].pol, rows[i].pol,
        rows[i].cand, rows[i].cand, rows[i].pin};
      tick(5);
      check("status_a", sa, rows[i].exp);
      check("irq_b", ib, rows[i].exp);
    end
    $display("table done");
    {ea, pa, ca, ta, pin, eb, pb, cb} = {32'h1, 32'h1, 2'h1, 32'h0, 32'h1, 32'h1, 1'b0};
    xa = 1;
    tick(5);
    xa = 0;
    pin = 1;
    xb = 1;
    tick(5);
    xb = 0;
    check("status_a", sa, 1'b1);
    check("status_b", sb, 1'b1);
    pin = 0;
    tick(5);
    check("status_a", sa, 1'b1);
    xa = 1;
    tick(1);
    xa = 0;
    check("status_a", sa, 1'b0);
    check("irq_a", ia, 1'b0);
    $display("edge done");
    eb = 0;
    for (int m = 1; m < 4; m++)
    begin
      cmd = m[1:0];
      tick(2);
      pin = 1;
      for (k = 0; k < 10 && wk !== 1'b1; k++)
        tick(1);
      check("wake_req", wk, 1'b1);
      check("irq_a", ia, 1'b0);
      cmd = 0;
      tick(8);
      check("irq_a", ia, 1'b1);
      {xa, pin} = {1'b1, 32'h0};
      tick(1);
      xa = 0;
      tick(3);
    end
    $display("wake done");
    {eb, pb, tb} = {32'h1, 32'h1, 1'b1};
    pin = 1;
    tick(2);
    xb = 1;
    tick(1);
    xb = 0;
    check("status_b", sb, 1'b1);
    tick(1);
    check("status_b", sb, 1'b1);
    pin = 0;
    tick(4);
    check("status_b", sb, 1'b1);
    check("irq_b", ib, 1'b1);
    xb = 1;
    tick(1);
    xb = 0;
    check("status_b", sb, 1'b0);
    check("irq_b", ib, 1'b0);
    $display("edge b done");
    pin = 1;
    tick(5);
    rst = 1;
    tick(2);
    check("status_a", sa, 1'b0);
    check("status_b", sb, 1'b0);
    check("irq_a", ia, 1'b0);
    check("irq_b", ib, 1'b0);
    check("wake_req", wk, 1'b0);
    rst = 0;
    tick(2);
    check("status_a", sa, 1'b0);
    tick(1);
    check("status_a", sa, 1'b1);
    check("status_b", sb, 1'b1);
    $display("reset done");
    final_report();
  end
  initial
  begin
    #20000;
    n_fail++;
    final_report();
  end
endmodule
